// ---- verif/test_timer_ctc_fast_pwm_modes.sv ----
// Purpose: Self-checking bench for the waveform timer
// Assumes: Prescale /1, so one timer clock per clock, except the divide-by-8 prescale test
// Notes: Waveforms are judged by measured high and low spans
`timescale 1ns/1ps
`default_nettype none
module test_timer_ctc_fast_pwm_modes;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic oa;
  logic oae;
  logic ob;
  logic obe;
  logic [31:0] rd;
  logic err;
  logic sel_b = 1'b0;
  int fail_count = 0;
  int checks = 0;
  wave_timer dut_u (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .WAVE_OUT_A_O(oa),
    .WAVE_OUT_A_OE_O(oae), .WAVE_OUT_B_O(ob), .WAVE_OUT_B_OE_O(obe));
  // ----------------------------------------
  // Clock, compare and bus tasks
  // ----------------------------------------
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ready; one idle edge keeps drives single
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic gap(input logic v, output int n);
    n = 0;
    while ((sel_b ? ob : oa) === v && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // Lets a new setting or buffered compare settle over one full period,
  // skips a partial phase, then times one high and one low span
  task automatic span(output int hi, output int lo);
    int t;
    repeat (12) @(posedge clk);
    gap(1'b1, t);
    gap(1'b0, t);
    gap(1'b1, hi);
    gap(1'b0, lo);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    chk({oa, oae, ob, obe}, 4'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_ctc;
    int hi;
    int lo;
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h000, 32'h914);
    span(hi, lo);
    chk(hi, 4);
    chk(lo, 4);
    chk(oae, 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd & 32'hb, 32'h2);
    $display("test clear on match done");
  endtask
  task automatic t_fast;
    int hi;
    int lo;
    apb(1'b1, 12'h010, 32'h9);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b1, 12'h000, 32'h19ae);
    span(hi, lo);
    chk(hi, 4);
    chk(lo, 6);
    // Channel B runs the same compare and action, pin enabled
    sel_b = 1'b1;
    span(hi, lo);
    sel_b = 1'b0;
    chk(hi, 4);
    chk(lo, 6);
    chk(obe, 1'b1);
    apb(1'b1, 12'h000, 32'h93e);
    span(hi, lo);
    chk(hi, 6);
    chk(lo, 4);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd & 32'h9, 32'h9);
    apb(1'b1, 12'h000, 32'h92e);
    apb(1'b1, 12'h008, 32'h0);
    span(hi, lo);
    chk(hi, 1);
    chk(lo, 9);
    // Compare at TOP: the match wins over bottom, so the output stays low
    apb(1'b1, 12'h008, 32'h9);
    repeat (25) @(posedge clk);
    gap(1'b0, lo);
    chk(lo, 3000);
    $display("test fast pwm done");
  endtask
  task automatic t_toggle;
    int hi;
    int lo;
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h000, 32'h91f);
    apb(1'b1, 12'h014, 32'hf);
    span(hi, lo);
    chk(hi, 5);
    chk(lo, 5);
    // Compare A defines TOP here, so the capture flag must stay clear
    apb(1'b0, 12'h014, 32'h0);
    chk(rd & 32'hb, 32'h3);
    $display("test fast toggle done");
  endtask
  // Clear-on-match toggle with the divide-by-8 timer clock
  task automatic t_prescale;
    int hi;
    int lo;
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'ha14);
    repeat (70) @(posedge clk);
    span(hi, lo);
    chk(hi, 32);
    chk(lo, 32);
    chk(oae, 1'b1);
    $display("test prescale done");
  endtask
  task automatic t_mask;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h000, 32'h100 + 32'(i + 5));
      apb(1'b1, 12'h00c, 32'hffff);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, (32'h100 << i) - 32'h1);
    end
    $display("test fixed top mask done");
  endtask
  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Run needs about 3.5k cycles; this leaves wide margin
  initial
  begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ctc();
    t_fast();
    t_toggle();
    t_mask();
    t_prescale();
    complete_run();
  end
endmodule // test_timer_ctc_fast_pwm_modes
`default_nettype wire

// ---- verif/wave_timer_assertions.sv ----
// Purpose: Port checker for the waveform timer
// Assumes: APB answers in the first access cycle
// Notes: Shadows action A from APB control writes
`timescale 1ns/1ps
`default_nettype none
module wave_timer_chk
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic WAVE_OUT_A_O,
  input wire logic WAVE_OUT_A_OE_O,
  input wire logic WAVE_OUT_B_O,
  input wire logic WAVE_OUT_B_OE_O
);
  // ----------------------------------------
  // Control shadow
  // ----------------------------------------
  logic [1:0] act_a_q;
  // Same edge as the design's own write
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      act_a_q <= 2'h0;
    else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h000)
      act_a_q <= PWDATA_I[5:4];
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  sequence s_ctrl_wr;
    s_access ##0 (PWRITE_I && PADDR_I == 12'h000);
  endsequence
  // Four idle cycles cover the output register lag
  sequence s_idle_act;
    (act_a_q == 2'h0) [*4];
  endsequence
  a_ready_access: assert property (s_access |-> PREADY_O)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_ready_cause: assert property (PREADY_O |-> s_access)
    else $error("ready outside access");
  a_err_unmapped: assert property (s_access ##0 (PADDR_I > 12'h014) |-> PSLVERR_O)
    else $error("unmapped access not refused");
  a_err_mapped: assert property
    (s_access ##0 (PADDR_I[1:0] == 2'h0 && PADDR_I <= 12'h014) |-> !PSLVERR_O)
    else $error("mapped access refused");
  a_rdata_upper: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_err_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("refused read not zero");
  a_pin_dir_a: assert property
    (s_ctrl_wr |-> ##2 WAVE_OUT_A_OE_O == $past(PWDATA_I[11], 2))
    else $error("pin A enable wrong");
  a_pin_dir_b: assert property
    (s_ctrl_wr |-> ##2 WAVE_OUT_B_OE_O == $past(PWDATA_I[12], 2))
    else $error("pin B enable wrong");
  a_idle_hold: assert property (s_idle_act |-> $stable(WAVE_OUT_A_O))
    else $error("output moved with no action");
  a_reset_clear: assert property
    ($fell(RST_I) |-> !WAVE_OUT_A_O && !WAVE_OUT_A_OE_O)
    else $error("output not cleared by reset");
endmodule // wave_timer_chk
bind wave_timer wave_timer_chk chk_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .WAVE_OUT_A_O(WAVE_OUT_A_O),
  .WAVE_OUT_A_OE_O(WAVE_OUT_A_OE_O), .WAVE_OUT_B_O(WAVE_OUT_B_O),
  .WAVE_OUT_B_OE_O(WAVE_OUT_B_OE_O));
`default_nettype wire

// ---- verilog/wave_timer.sv ----
// How it works
// - Modes 4 and 12 clear counter at match
// - Clear-on-match sets flag of TOP register
// - Clear-on-match TOP unbuffered, missed match wraps
// - Action 1 toggles output A on match
// - Pin drives only when direction bit set
// - Overflow flag set on MAX to zero
// - Fast modes count bottom to TOP, restart
// - Fast TOP fixed, capture or compare A
// - Action 2 clears on match, 3 sets
// - Fast PWM overflow flag set at TOP
// - Fixed TOP masks upper compare bits
// - Fast PWM capture TOP writes immediate
// - Fast PWM compare A buffered until TOP
// - Extreme compare values give spike or level
// - Fast PWM toggle keeps buffering active
// - Period TOP+1 timer clocks, prescaled clock
// - Toggle frequency follows compare A value
// - Action 0 leaves output untouched
// - Counter write blocks next match
// - Reset clears output registers
// Purpose: 16-bit timer with clear-on-match and fast PWM waveforms, APB slave
// Assumes: Single 100 MHz clock, APB with zero wait states
// Notes: Flags clear by writing one; a set in the same cycle wins
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wave_timer_consts.svh"
module wave_timer
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic WAVE_OUT_A_O,
  output logic WAVE_OUT_A_OE_O,
  output logic WAVE_OUT_B_O,
  output logic WAVE_OUT_B_OE_O
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  wave_timer_pkg::ctrl_type ctrl_q;
  logic [15:0] count_q;
  logic [15:0] cmpa_q;
  logic [15:0] cmpa_buf_q;
  logic [15:0] cmpb_q;
  logic [15:0] cmpb_buf_q;
  logic [15:0] captop_q;
  logic [3:0] flags_q;
  logic [9:0] pre_cnt_q;
  logic block_q;
  logic wave_a_q;
  logic wave_b_q;
  logic wr_en;
  logic rd_en;
  logic tick;
  logic is_ctc;
  logic is_fast;
  logic fixed_top;
  logic [15:0] top;
  logic at_top;
  logic match_a;
  logic match_b;
  logic count_wr;
  logic [15:0] wmask;
  logic [3:0] flag_set;
  // Compare value masked to the active fixed TOP width
  function automatic logic [15:0] mask_top(input logic [15:0] v, input logic [15:0] m);
    mask_top = v & m;
  endfunction
  // Next output level for one channel on match or bottom
  // Bottom restores the level opposite to the match action; a match in the
  // same cycle wins, so a compare value equal to TOP holds the match level
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic fast, input logic match, input logic bottom);
    wave_next = cur;
    if (fast && bottom && act[1])
      wave_next = ~act[0];
    if (match)
    begin
      unique case (act)
        2'h0: wave_next = cur;
        2'h1: wave_next = ~cur;
        2'h2: wave_next = 1'b0;
        2'h3: wave_next = 1'b1;
      endcase
    end
  endfunction
  // ----------------------------------------
  // Bus decode and mode decode
  // ----------------------------------------
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign count_wr = wr_en && (PADDR_I == `OFS_COUNT);
  assign is_ctc = (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_CTC_A))
               || (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_CTC_CAP));
  assign is_fast = (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_FAST8))
                || (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_FAST9))
                || (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_FAST10))
                || (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_FAST_CAP))
                || (ctrl_q.waveform_mode_sel == 4'(wave_timer_pkg::MODE_FAST_A));
  assign fixed_top = is_fast && !ctrl_q.waveform_mode_sel[3];
  // TOP source selection
  always_comb
  begin
    unique case (ctrl_q.waveform_mode_sel)
      4'h5: top = `TOP_8BIT;
      4'h6: top = `TOP_9BIT;
      4'h7: top = `TOP_10BIT;
      4'h4, 4'hf: top = cmpa_q;
      4'hc, 4'he: top = captop_q;
      default: top = `COUNT_MAX;
    endcase
    wmask = fixed_top ? top : `COUNT_MAX;
  end
  // Full-width compares; a write to the counter suppresses the next one
  assign at_top = (count_q == top);
  assign match_a = !block_q && (count_q == cmpa_q);
  assign match_b = !block_q && (count_q == cmpb_q);

  // ----------------------------------------
  // Prescaler: divide by 1, 8, 64, 256 or 1024, 0 stops the timer
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      pre_cnt_q <= 10'h000;
    else
      pre_cnt_q <= pre_cnt_q + 10'h001;
  end

  always_comb
  begin
    unique case (ctrl_q.prescale_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_cnt_q[2:0] == 3'h7);
      3'h3: tick = (pre_cnt_q[5:0] == 6'h3f);
      3'h4: tick = (pre_cnt_q[7:0] == 8'hff);
      3'h5: tick = (pre_cnt_q == 10'h3ff);
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      count_q <= `COUNT_BOTTOM;
    else if (count_wr)
      count_q <= PWDATA_I[15:0];
    else if (tick)
    begin
      if ((is_ctc || is_fast) && at_top)
        count_q <= `COUNT_BOTTOM;
      else
        count_q <= count_q + 16'h0001;
    end
  end

  // Match blocking lasts until the next timer clock has passed
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      block_q <= 1'b0;
    else if (count_wr)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end

  // ----------------------------------------
  // Compare registers and buffers
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cmpa_buf_q <= 16'h0000;
      cmpb_buf_q <= 16'h0000;
    end
    else if (wr_en && PADDR_I == `OFS_CMPA)
      cmpa_buf_q <= mask_top(PWDATA_I[15:0], wmask);
    else if (wr_en && PADDR_I == `OFS_CMPB)
      cmpb_buf_q <= mask_top(PWDATA_I[15:0], wmask);
  end

  // Buffered in fast PWM, loaded at TOP; direct otherwise
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cmpa_q <= 16'h0000;
      cmpb_q <= 16'h0000;
    end
    else if (!is_fast)
    begin
      if (wr_en && PADDR_I == `OFS_CMPA)
        cmpa_q <= mask_top(PWDATA_I[15:0], wmask);
      if (wr_en && PADDR_I == `OFS_CMPB)
        cmpb_q <= mask_top(PWDATA_I[15:0], wmask);
    end
    else if (tick && at_top)
    begin
      cmpa_q <= cmpa_buf_q;
      cmpb_q <= cmpb_buf_q;
    end
  end

  // Capture/TOP register is never buffered
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      captop_q <= 16'h0000;
    else if (wr_en && PADDR_I == `OFS_CAPTOP)
      captop_q <= PWDATA_I[15:0];
  end

  // ----------------------------------------
  // Flags: hardware sets, writing one clears, set wins
  // ----------------------------------------
  always_comb
  begin
    flag_set = 4'h0;
    if (tick)
    begin
      flag_set[`FLAG_CMPA_BIT] = match_a;
      flag_set[`FLAG_CMPB_BIT] = match_b;
      if (is_fast && at_top)
        flag_set[`FLAG_OVF_BIT] = 1'b1;
      else if (count_q == `COUNT_MAX)
        flag_set[`FLAG_OVF_BIT] = 1'b1;
      if (at_top && (ctrl_q.waveform_mode_sel inside {4'hc, 4'he}))
        flag_set[`FLAG_CAP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      flags_q <= 4'h0;
    else if (wr_en && PADDR_I == `OFS_FLAGS)
      flags_q <= (flags_q & ~PWDATA_I[3:0]) | flag_set;
    else
      flags_q <= flags_q | flag_set;
  end

  // ----------------------------------------
  // Waveform output registers
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end
    else if (tick)
    begin
      // Match after bottom so a compare equal to TOP holds the match level
      wave_a_q <= wave_next(wave_a_q, ctrl_q.output_action_a, is_fast, match_a,
                            at_top && is_fast);
      wave_b_q <= wave_next(wave_b_q, ctrl_q.output_action_b, is_fast,
                            match_b && ctrl_q.output_action_b != 2'h1, at_top && is_fast);
    end
  end

  // Pin drive follows the direction bits
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      WAVE_OUT_A_O <= 1'b0;
      WAVE_OUT_A_OE_O <= 1'b0;
      WAVE_OUT_B_O <= 1'b0;
      WAVE_OUT_B_OE_O <= 1'b0;
    end
    else
    begin
      WAVE_OUT_A_O <= wave_a_q;
      WAVE_OUT_A_OE_O <= ctrl_q.wave_pin_dir_a;
      WAVE_OUT_B_O <= wave_b_q;
      WAVE_OUT_B_OE_O <= ctrl_q.wave_pin_dir_b;
    end
  end

  // ----------------------------------------
  // APB slave: no wait states, read data in access phase
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      ctrl_q <= '0;
    else if (wr_en && PADDR_I == `OFS_CTRL)
      ctrl_q <= PWDATA_I[12:0];
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
      PREADY_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= PSEL_I && !PENABLE_I; // High in the first access cycle, no waits
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      if (PSEL_I && !PENABLE_I && !(PADDR_I inside {`OFS_CTRL, `OFS_COUNT, `OFS_CMPA,
          `OFS_CMPB, `OFS_CAPTOP, `OFS_FLAGS}))
        PSLVERR_O <= 1'b1;
      if (rd_en)
      begin
        unique case (PADDR_I)
          `OFS_CTRL: PRDATA_O <= {19'h00000, ctrl_q};
          `OFS_COUNT: PRDATA_O <= {16'h0000, count_q};
          `OFS_CMPA: PRDATA_O <= {16'h0000, is_fast ? cmpa_buf_q : cmpa_q};
          `OFS_CMPB: PRDATA_O <= {16'h0000, is_fast ? cmpb_buf_q : cmpb_q};
          `OFS_CAPTOP: PRDATA_O <= {16'h0000, captop_q};
          `OFS_FLAGS: PRDATA_O <= {28'h0000000, flags_q};
          default: PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // wave_timer
`default_nettype wire

// ---- verilog/wave_timer_consts.svh ----
// Purpose: Constants for the waveform timer block
// Assumes: 16-bit counter, APB word registers
// Notes: Offsets are byte addresses
`ifndef WAVE_TIMER_CONSTS_SVH
`define WAVE_TIMER_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_COUNT 12'h004
`define OFS_CMPA 12'h008
`define OFS_CMPB 12'h00c
`define OFS_CAPTOP 12'h010
`define OFS_FLAGS 12'h014
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_ACTA_LSB 4
`define CTRL_ACTB_LSB 6
`define CTRL_PRE_LSB 8
`define CTRL_DIRA_BIT 11
`define CTRL_DIRB_BIT 12
// ----------------------------------------
// Flag bits and fixed values
// ----------------------------------------
`define FLAG_OVF_BIT 0
`define FLAG_CMPA_BIT 1
`define FLAG_CMPB_BIT 2
`define FLAG_CAP_BIT 3
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define COUNT_MAX 16'hffff
`define COUNT_BOTTOM 16'h0000
`endif

// ---- verilog/wave_timer_pkg.sv ----
// Purpose: Types for the waveform timer block
// Assumes: Constants live in wave_timer_consts.svh
// Notes: Types only
package wave_timer_pkg;
  // Waveform mode selector values handled by this block
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_CTC_A = 4'h4,
    MODE_FAST8 = 4'h5,
    MODE_FAST9 = 4'h6,
    MODE_FAST10 = 4'h7,
    MODE_CTC_CAP = 4'hc,
    MODE_FAST_CAP = 4'he,
    MODE_FAST_A = 4'hf
  } waveform_mode_type;

  // Control register fields
  typedef struct packed {
    logic wave_pin_dir_b;
    logic wave_pin_dir_a;
    logic [2:0] prescale_sel;
    logic [1:0] output_action_b;
    logic [1:0] output_action_a;
    logic [3:0] waveform_mode_sel;
  } ctrl_type;
endpackage
